// ### shared/dss_pkg.sv
// dss_pkg: constants, register layout and state encodings of the debug serial block
// assumes an APB slave with 32-bit data in which each register takes one aligned word
package dss_pkg;

  // ****************************************************************
  // register indices (byte address = 4 * index)
  // ****************************************************************
  localparam logic [23:0] DSS_IDX_DATA    = 24'hFFE080;
  localparam logic [23:0] DSS_IDX_BAUD    = 24'hFFE082;
  localparam logic [23:0] DSS_IDX_STATUS  = 24'hFFE085;
  localparam logic [23:0] DSS_IDX_CONTROL = 24'hFFE086;

  // ****************************************************************
  // status fields
  // ****************************************************************
  localparam int DSS_ST_FULL  = 7;
  localparam int DSS_ST_OVR   = 6;
  localparam int DSS_ST_FRM   = 5;
  localparam int DSS_ST_BRK   = 4;
  localparam int DSS_ST_EMPTY = 3;
  localparam int DSS_ST_COL   = 2;
  localparam int DSS_ST_RXACT = 1;
  localparam int DSS_ST_TXACT = 0;
  localparam logic [7:0] DSS_STATUS_RST = 8'h08;

  // ****************************************************************
  // control fields
  // ****************************************************************
  localparam int DSS_CT_LOCK   = 7;
  localparam int DSS_CT_DBGEN  = 6;
  localparam int DSS_CT_RSV_HI = 5;
  localparam int DSS_CT_RSV_LO = 4;
  localparam int DSS_CT_CHKAPP = 3;
  localparam int DSS_CT_SPEN   = 2;
  localparam int DSS_CT_AUTOBAUD_CHAR_SELECT = 1;
  localparam int DSS_CT_AUTOBAUD_SEARCH = 0;
  localparam logic [7:0] DSS_CONTROL_RST = 8'hC9;
  localparam logic [15:0] DSS_RELOAD_RST = 16'h0000;

  // ****************************************************************
  // timing and coding
  // ****************************************************************
  // reload is eight times the clocks per bit
  localparam int DSS_RELOAD_SHIFT = 3;
  localparam logic [7:0] DSS_AB_CHAR_0 = 8'h80;
  localparam logic [7:0] DSS_AB_CHAR_1 = 8'h0D;
  // low span measured: 80H gives eight bit times, 0DH one bit time
  localparam int DSS_AB_BITS_0 = 8;
  localparam int DSS_AB_BITS_1 = 1;
  localparam int DSS_BREAK_BITS = 10;
  localparam logic [7:0] DSS_CRC_POLY = 8'h07;
  localparam logic [7:0] DSS_CRC_INIT = 8'h00;

  // ****************************************************************
  // state encodings
  // ****************************************************************
  typedef enum logic [4:0] {
    DSS_RX_IDLE  = 5'b00001,
    DSS_RX_START = 5'b00010,
    DSS_RX_DATA  = 5'b00100,
    DSS_RX_STOP  = 5'b01000,
    DSS_RX_BAUD  = 5'b10000
  } dss_rx_t;

  typedef enum logic [3:0] {
    DSS_TX_IDLE  = 4'b0001,
    DSS_TX_START = 4'b0010,
    DSS_TX_DATA  = 4'b0100,
    DSS_TX_STOP  = 4'b1000
  } dss_tx_t;

endpackage : dss_pkg

// ### rtl/dss_top.sv
// dss_top: status and control of a single-pin debug serial port with APB registers
// assumes pclk at 125 MHz, presetn asynchronous active low, pin and option bit asynchronous
//
// Summary of operation
// - receive full sets on load, clears read/W1C
// - overrun when loading over unread byte
// - framing error sticky, cleared by writing one
// - ten low bits flag break, write-one clear
// - transmit empty clears on write, sets on move
// - writing one to empty discards pending byte
// - collision sticky, cleared by writing one
// - receiver active while taking a character
// - transmitter active while shifting a character
// - lock rejects control writes, set at reset
// - option bit high forces lock on
// - debugger mode routes received characters to commands
// - debugger enable unwritable while locked
// - check byte appended to debugger transfers
// - serial port enable bit used only outside debugger mode, port always on in debugger mode
// - auto-baud character 80H or 0DH
// - auto-baud character unwritable in debugger mode
// - debugger-mode framing errors restart auto-baud search
// - search bit unwritable in debugger mode
// - reload equals eight times clocks per bit
`timescale 1ns/1ps
`default_nettype none

module dss_top
  import dss_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        debug_pin_in,
  output logic             debug_pin_out,
  output logic             debug_pin_oe_n,
  input  wire logic        debug_serial_option_bit,
  output logic             dbg_cmd_valid,
  output logic      [7:0]  dbg_cmd_byte
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic        pin_m;
    logic        pin_s;
    logic        pin_p;
    logic        opt_m;
    logic        opt_s;
    dss_rx_t     rx_st;
    logic [15:0] rx_cnt;
    logic [2:0]  rx_bitn;
    logic [7:0]  rx_sh;
    logic [7:0]  rx_data;
    dss_tx_t     tx_st;
    logic [15:0] tx_cnt;
    logic [2:0]  tx_bitn;
    logic [7:0]  tx_sh;
    logic [7:0]  tx_hold;
    logic        tx_bit;
    logic        tx_crc;
    logic [7:0]  crc;
    logic        crc_any;
    logic        full;
    logic        ovr;
    logic        frm;
    logic        brk;
    logic        empty;
    logic        col;
    logic        lock;
    logic        dbg_en;
    logic        chk_app;
    logic        sp_en;
    logic        ab_char;
    logic        ab_srch;
    logic [15:0] reload;
    logic [31:0] rdata;
    logic        slverr;
    logic        cmd_v;
    logic [7:0]  cmd_b;
  } dss_state_t;

  dss_state_t r;
  dss_state_t n;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic dss_hit(input logic [31:0] a, input logic [23:0] idx);
    dss_hit = (a[31:2] == {6'h00, idx});
  endfunction : dss_hit
  function automatic logic [7:0] dss_crc_upd(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    logic       fb;
    x = c;
    for (int i = 7; i >= 0; i--) begin
      fb = x[7] ^ d[i];
      x  = {x[6:0], 1'b0} ^ (fb ? DSS_CRC_POLY : 8'h00);
    end
    dss_crc_upd = x;
  endfunction : dss_crc_upd
  logic [15:0] bclk;
  logic [15:0] half;
  logic        lock_eff;
  logic        port_en;
  logic        acc_wr;
  logic        acc_rd;
  logic        setup;
  logic        hit_any;
  logic [7:0]  wd;
  logic        rx_done;
  logic        rx_err;
  // ****************************************************************
  // derived control
  // ****************************************************************
  always_comb begin
    bclk = {{DSS_RELOAD_SHIFT{1'b0}}, r.reload[15:DSS_RELOAD_SHIFT]};
    if (bclk == 16'h0000) begin
      bclk = 16'h0001;
    end
    half     = {1'b0, bclk[15:1]};
    lock_eff = r.lock | r.opt_s;
    port_en  = r.dbg_en | r.sp_en;
    setup    = psel & ~penable;
    acc_wr   = psel & penable & pwrite & pstrb[0];
    acc_rd   = psel & penable & ~pwrite;
    hit_any  = dss_hit(paddr, DSS_IDX_DATA) | dss_hit(paddr, DSS_IDX_BAUD) |
               dss_hit(paddr, DSS_IDX_STATUS) | dss_hit(paddr, DSS_IDX_CONTROL);
    wd       = pwdata[7:0];
  end
  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    n = r;
    rx_done = 1'b0;
    rx_err  = 1'b0;
    n.cmd_v = 1'b0;

    // synchronisers
    n.pin_m = debug_pin_in;
    n.pin_s = r.pin_m;
    n.pin_p = r.pin_s;
    n.opt_m = debug_serial_option_bit;
    n.opt_s = r.opt_m;

    // read data is captured in the setup phase
    if (setup) begin
      n.slverr = ~hit_any;
      n.rdata  = 32'h0000_0000;
      if (dss_hit(paddr, DSS_IDX_DATA)) begin
        n.rdata[7:0] = r.rx_data;
      end
      if (dss_hit(paddr, DSS_IDX_BAUD)) begin
        n.rdata[15:0] = r.reload;
      end
      if (dss_hit(paddr, DSS_IDX_STATUS)) begin
        n.rdata[7:0] = {r.full, r.ovr, r.frm, r.brk, r.empty, r.col,
                        r.rx_st != DSS_RX_IDLE,
                        r.tx_st != DSS_TX_IDLE};
      end
      if (dss_hit(paddr, DSS_IDX_CONTROL)) begin
        n.rdata[7:0] = {lock_eff, r.dbg_en, 2'b00,
                        r.chk_app, r.sp_en, r.ab_char, r.ab_srch};
      end
    end

    // software clears and writes
    if (acc_rd && dss_hit(paddr, DSS_IDX_DATA)) begin
      n.full = 1'b0;
    end
    if (acc_wr && dss_hit(paddr, DSS_IDX_STATUS)) begin
      if (wd[DSS_ST_FULL]) n.full = 1'b0;
      if (wd[DSS_ST_OVR])  n.ovr  = 1'b0;
      if (wd[DSS_ST_FRM])  n.frm  = 1'b0;
      if (wd[DSS_ST_BRK])  n.brk  = 1'b0;
      if (wd[DSS_ST_COL])  n.col  = 1'b0;
    end
    if (acc_wr && dss_hit(paddr, DSS_IDX_CONTROL) && !lock_eff) begin
      n.lock    = wd[DSS_CT_LOCK];
      n.dbg_en  = wd[DSS_CT_DBGEN];
      n.chk_app = wd[DSS_CT_CHKAPP];
      n.sp_en   = wd[DSS_CT_SPEN];
      if (!r.dbg_en) begin
        n.ab_char = wd[DSS_CT_AUTOBAUD_CHAR_SELECT];
        n.ab_srch = wd[DSS_CT_AUTOBAUD_SEARCH];
      end
    end
    if (acc_wr && dss_hit(paddr, DSS_IDX_BAUD)) begin
      n.reload = pwdata[15:0];
    end

    // receiver
    case (r.rx_st)
      DSS_RX_IDLE: begin
        n.rx_cnt = {15'h0000, r.ab_srch};
        if (port_en && r.pin_p && !r.pin_s) begin
          n.rx_st = r.ab_srch ? DSS_RX_BAUD : DSS_RX_START;
        end
      end
      DSS_RX_BAUD: begin
        if (r.pin_s) begin
          if (r.ab_char) begin
            n.reload = 16'(({16'h0000, r.rx_cnt} << DSS_RELOAD_SHIFT) / DSS_AB_BITS_1);
          end else begin
            n.reload = 16'(({16'h0000, r.rx_cnt} << DSS_RELOAD_SHIFT) / DSS_AB_BITS_0);
          end
          n.ab_srch = 1'b0;
          n.rx_st   = DSS_RX_IDLE;
        end else if (r.rx_cnt != 16'hFFFF) begin
          n.rx_cnt = r.rx_cnt + 16'h0001;
        end
      end
      DSS_RX_START: begin
        n.rx_cnt = r.rx_cnt + 16'h0001;
        if (r.rx_cnt >= half) begin
          n.rx_cnt  = 16'h0000;
          n.rx_bitn = 3'd0;
          n.rx_st   = r.pin_s ? DSS_RX_IDLE : DSS_RX_DATA;
        end
      end
      DSS_RX_DATA: begin
        n.rx_cnt = r.rx_cnt + 16'h0001;
        if (r.rx_cnt >= bclk - 16'h0001) begin
          n.rx_cnt  = 16'h0000;
          n.rx_sh   = {r.pin_s, r.rx_sh[7:1]};
          n.rx_bitn = r.rx_bitn + 3'd1;
          if (r.rx_bitn == 3'd7) begin
            n.rx_st = DSS_RX_STOP;
          end
        end
      end
      DSS_RX_STOP: begin
        n.rx_cnt = r.rx_cnt + 16'h0001;
        if (r.rx_cnt >= bclk - 16'h0001) begin
          n.rx_st = DSS_RX_IDLE;
          if (!r.pin_s) begin
            n.frm  = 1'b1;
            rx_err = 1'b1;
            // start, eight data and stop low: DSS_BREAK_BITS in a row
            if (r.rx_sh == 8'h00) begin
              n.brk = 1'b1;
            end
          end else begin
            rx_done = 1'b1;
          end
        end
      end
      default: begin
        n.rx_st = DSS_RX_IDLE;
      end
    endcase

    if (rx_done) begin
      if (r.dbg_en) begin
        n.cmd_v = 1'b1;
        n.cmd_b = r.rx_sh;
      end else begin
        if (r.full) begin
          n.ovr = 1'b1;
        end
        n.rx_data = r.rx_sh;
        n.full    = 1'b1;
      end
    end
    if (rx_err && r.dbg_en) begin
      n.ab_srch = 1'b1;
    end

    // transmitter
    case (r.tx_st)
      DSS_TX_IDLE: begin
        n.tx_bit = 1'b1;
        n.tx_cnt = 16'h0000;
        if (port_en && !r.empty) begin
          n.tx_sh  = r.tx_hold;
          n.empty  = 1'b1;
          n.tx_crc = 1'b0;
          n.tx_st  = DSS_TX_START;
          n.tx_bit = 1'b0;
          if (r.dbg_en) begin
            n.crc     = dss_crc_upd(r.crc, r.tx_hold);
            n.crc_any = 1'b1;
          end
        end else if (r.dbg_en && r.chk_app && r.crc_any) begin
          n.tx_sh   = r.crc;
          n.tx_crc  = 1'b1;
          n.crc     = DSS_CRC_INIT;
          n.crc_any = 1'b0;
          n.tx_st   = DSS_TX_START;
          n.tx_bit  = 1'b0;
        end else if (!r.chk_app || !r.dbg_en) begin
          n.crc     = DSS_CRC_INIT;
          n.crc_any = 1'b0;
        end
      end
      DSS_TX_START, DSS_TX_DATA, DSS_TX_STOP: begin
        n.tx_cnt = r.tx_cnt + 16'h0001;
        if (r.tx_cnt == half && r.pin_s != r.tx_bit) begin
          n.col = 1'b1;
        end
        if (r.tx_cnt >= bclk - 16'h0001) begin
          n.tx_cnt = 16'h0000;
          if (r.tx_st == DSS_TX_START) begin
            n.tx_st   = DSS_TX_DATA;
            n.tx_bitn = 3'd0;
            n.tx_bit  = r.tx_sh[0];
            n.tx_sh   = {1'b0, r.tx_sh[7:1]};
          end else if (r.tx_st == DSS_TX_DATA) begin
            n.tx_bitn = r.tx_bitn + 3'd1;
            if (r.tx_bitn == 3'd7) begin
              n.tx_st  = DSS_TX_STOP;
              n.tx_bit = 1'b1;
            end else begin
              n.tx_bit = r.tx_sh[0];
              n.tx_sh  = {1'b0, r.tx_sh[7:1]};
            end
          end else begin
            n.tx_st  = DSS_TX_IDLE;
            n.tx_bit = 1'b1;
          end
        end
      end
      default: begin
        n.tx_st = DSS_TX_IDLE;
      end
    endcase

    // a data write loads the holding register after any move above
    if (acc_wr && dss_hit(paddr, DSS_IDX_DATA)) begin
      n.tx_hold = wd;
      n.empty   = 1'b0;
    end
    if (acc_wr && dss_hit(paddr, DSS_IDX_STATUS) && wd[DSS_ST_EMPTY]) begin
      n.empty = 1'b1;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r         <= '0;
      r.pin_m   <= 1'b1;
      r.pin_s   <= 1'b1;
      r.pin_p   <= 1'b1;
      r.opt_m   <= 1'b1;
      r.opt_s   <= 1'b1;
      r.rx_st   <= DSS_RX_IDLE;
      r.tx_st   <= DSS_TX_IDLE;
      r.tx_bit  <= 1'b1;
      r.crc     <= DSS_CRC_INIT;
      r.full    <= DSS_STATUS_RST[DSS_ST_FULL];
      r.ovr     <= DSS_STATUS_RST[DSS_ST_OVR];
      r.frm     <= DSS_STATUS_RST[DSS_ST_FRM];
      r.brk     <= DSS_STATUS_RST[DSS_ST_BRK];
      r.empty   <= DSS_STATUS_RST[DSS_ST_EMPTY];
      r.col     <= DSS_STATUS_RST[DSS_ST_COL];
      r.lock    <= DSS_CONTROL_RST[DSS_CT_LOCK];
      r.dbg_en  <= DSS_CONTROL_RST[DSS_CT_DBGEN];
      r.chk_app <= DSS_CONTROL_RST[DSS_CT_CHKAPP];
      r.sp_en   <= DSS_CONTROL_RST[DSS_CT_SPEN];
      r.ab_char <= DSS_CONTROL_RST[DSS_CT_AUTOBAUD_CHAR_SELECT];
      r.ab_srch <= DSS_CONTROL_RST[DSS_CT_AUTOBAUD_SEARCH];
      r.reload  <= DSS_RELOAD_RST;
    end else begin
      r <= n;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign prdata         = r.rdata;
  assign pslverr        = r.slverr;
  assign pready         = 1'b1;
  assign debug_pin_out  = r.tx_bit;
  assign debug_pin_oe_n = (r.tx_st == DSS_TX_IDLE);
  assign dbg_cmd_valid  = r.cmd_v;
  assign dbg_cmd_byte   = r.cmd_b;

endmodule : dss_top

`default_nettype wire

// ### test/dss_sva.sv
// dss_sva: port-level assertions for dss_top
// assumes one clock pclk and presetn asynchronous active low
`timescale 1ns/1ps
`default_nettype none
module dss_sva
  import dss_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        debug_pin_in,
  input wire logic        debug_pin_out,
  input wire logic        debug_pin_oe_n,
  input wire logic        debug_serial_option_bit,
  input wire logic        dbg_cmd_valid,
  input wire logic [7:0]  dbg_cmd_byte
);
  localparam logic [31:0] A_ST = {6'h00, DSS_IDX_STATUS, 2'b00};
  localparam logic [31:0] A_CT = {6'h00, DSS_IDX_CONTROL, 2'b00};
  logic mapped;
  assign mapped = paddr == A_ST || paddr == A_CT || paddr == {6'h00, DSS_IDX_DATA, 2'b00}
                  || paddr == {6'h00, DSS_IDX_BAUD, 2'b00};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence rd_setup(logic [31:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  sequence frame_start;
    $fell(debug_pin_oe_n);
  endsequence
  sequence tx_held;
    !debug_pin_oe_n [*8];
  endsequence
  unmapped_err_a: assert property (psel && !penable && !mapped |=> pslverr)
    else $error("unmapped access without error");
  mapped_ok_a: assert property (psel && !penable && mapped |=> !pslverr)
    else $error("mapped access flagged as error");
  rsv_zero_a: assert property (rd_setup(A_CT) |=>
    prdata[31:8] == 24'h000000 && prdata[5:4] == 2'b00)
    else $error("reserved control bits not zero");
  lock_forced_a: assert property (rd_setup(A_CT) ##0 (debug_serial_option_bit
    && $past(debug_serial_option_bit, 2)) |=> prdata[DSS_CT_LOCK]) else $error("lock not forced");
  start_low_a: assert property (frame_start |-> !debug_pin_out)
    else $error("frame does not open with a low start bit");
  frame_len_a: assert property (frame_start |-> tx_held)
    else $error("transmit frame too short");
  txact_rd_a: assert property (rd_setup(A_ST) ##0 !debug_pin_oe_n |=> prdata[DSS_ST_TXACT])
    else $error("transmitter active not reported");
  idle_level_a: assert property (debug_pin_oe_n |-> debug_pin_out)
    else $error("released pin output not high");
  cmd_pulse_a: assert property (dbg_cmd_valid |=> !dbg_cmd_valid)
    else $error("command pulse longer than one cycle");
  cmd_hold_a: assert property ($changed(dbg_cmd_byte) |-> dbg_cmd_valid)
    else $error("command byte changed without pulse");
  rd_stand_a: assert property (psel && penable |=> $stable(prdata))
    else $error("read data moved in access phase");
endmodule : dss_sva
bind dss_top dss_sva u_dss_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .debug_pin_in(debug_pin_in),
  .debug_pin_out(debug_pin_out), .debug_pin_oe_n(debug_pin_oe_n),
  .debug_serial_option_bit(debug_serial_option_bit), .dbg_cmd_valid(dbg_cmd_valid),
  .dbg_cmd_byte(dbg_cmd_byte));
`default_nettype wire

// ### test/dss_host_model.sv
// dss_host_model: debug host on the single pin, 8N1 LSB first
// assumes the line is pulled high wherever nobody drives it low
`timescale 1ns/1ps
`default_nettype none
module dss_host_model (
  input  wire logic        pclk,
  input  wire logic        line,
  input  wire logic        dev_oe_n,
  input  wire logic [15:0] bit_clks,
  input  wire logic        hold_low,
  output logic             host_drv
);
  logic       drv_r = 1'b1;
  logic [7:0] rx_b;
  logic [7:0] rxq[$];
  // holding low fights every one the device sends
  assign host_drv = drv_r & ~hold_low;
  task automatic send(input logic [7:0] b, input logic stop_bit);
    logic [9:0] f;
    f = {stop_bit, b, 1'b0};
    @(posedge pclk);
    for (int i = 0; i < 10; i++) begin
      drv_r <= f[i];
      repeat (bit_clks) @(posedge pclk);
    end
    drv_r <= 1'b1;
  endtask : send
  // samples device frames at mid-bit
  always begin
    wait (dev_oe_n === 1'b0 && line === 1'b0);
    repeat (bit_clks / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_clks) @(posedge pclk);
      rx_b[i] = line;
    end
    repeat (bit_clks) @(posedge pclk);
    rxq.push_back(rx_b);
  end
endmodule : dss_host_model
`default_nettype wire

// ### test/debug_serial_status_control_tb.sv
// debug_serial_status_control_tb: self-checking bench for dss_top
// assumes dss_pkg, the bound checker and dss_host_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module debug_serial_status_control_tb
  import dss_pkg::*;
;
  localparam int CPB = 16;
  localparam logic [31:0] A_DT = {6'h00, DSS_IDX_DATA, 2'b00};
  localparam logic [31:0] A_BR = {6'h00, DSS_IDX_BAUD, 2'b00};
  localparam logic [31:0] A_ST = {6'h00, DSS_IDX_STATUS, 2'b00};
  localparam logic [31:0] A_CT = {6'h00, DSS_IDX_CONTROL, 2'b00};
  logic        pclk, pready, pslverr, pin_out, pin_oe_n, host_drv, line, cmd_valid, err;
  logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        opt = 1'b1, hold_low = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'hF;
  logic [7:0]  cmd_byte, b1;
  logic [7:0]  cmdq[$];
  int          n_errors = 0, n_tests = 0, cyc = 0, seed = 32'h881CFE72;
  assign line = host_drv & (pin_oe_n ? 1'b1 : pin_out);
  dss_top u_dss_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .debug_pin_in(line), .debug_pin_out(pin_out),
    .debug_pin_oe_n(pin_oe_n), .debug_serial_option_bit(opt), .dbg_cmd_valid(cmd_valid),
    .dbg_cmd_byte(cmd_byte));
  dss_host_model u_dss_host_model (.pclk(pclk), .line(line), .dev_oe_n(pin_oe_n),
    .bit_clks(16'(CPB)), .hold_low(hold_low), .host_drv(host_drv));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cmd_valid === 1'b1) cmdq.push_back(cmd_byte);
    if (cyc == 30000) begin
      n_errors = n_errors + 1;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask : rdchk
  function automatic logic [7:0] crc8(input logic [7:0] b);
    logic [7:0] c;
    c = DSS_CRC_INIT ^ b;
    for (int i = 0; i < 8; i++) c = {c[6:0], 1'b0} ^ (c[7] ? DSS_CRC_POLY : 8'h00);
    return c;
  endfunction : crc8
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(A_ST, 32'hFFFFFFFF, {24'h0, DSS_STATUS_RST});
    rdchk(A_CT, 32'hFFFFFFFF, {24'h0, DSS_CONTROL_RST});
    apb(1'b0, 32'h03FF8204, 32'h0);
    chk({31'h00000000, err}, 32'h00000001);
    chk(rd, 32'h00000000);
    $display("done reset");
    for (int i = 0; i < 4; i++) begin
      opt <= i[0];
      repeat (4) @(posedge pclk);
      apb(1'b1, A_CT, {24'h0, 8'($random(seed)) & 8'hCF});
      rdchk(A_CT, 32'hFF, {24'h0, DSS_CONTROL_RST});
    end
    $display("done lock");
    u_dss_host_model.send(DSS_AB_CHAR_0, 1'b1);
    repeat (CPB) @(posedge pclk);
    rdchk(A_BR, 32'hFFFF, 32'(CPB << DSS_RELOAD_SHIFT));
    rdchk(A_CT, 32'h01, 32'h0);
    $display("done autobaud");
    for (int i = 0; i < 6; i++) begin
      b1 = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
      cmdq.delete();
      fork
        u_dss_host_model.send(b1, 1'b1);
        begin
          repeat (5 * CPB) @(posedge pclk);
          rdchk(A_ST, 32'h02, 32'h02);
        end
      join
      repeat (4) @(posedge pclk);
      chk({cmdq.size() == 1, cmdq[0]}, {1'b1, b1});
    end
    rdchk(A_ST, 32'h80, 32'h0);
    $display("done command receive");
    u_dss_host_model.rxq.delete();
    b1 = 8'($random(seed));
    apb(1'b1, A_DT, {24'h0, b1});
    apb(1'b1, A_DT, {24'h0, ~b1});
    rdchk(A_ST, 32'h09, 32'h01);
    apb(1'b1, A_ST, 32'h08);
    rdchk(A_ST, 32'h08, 32'h08);
    repeat (32 * CPB) @(posedge pclk);
    chk(32'(u_dss_host_model.rxq.size()), 32'h2);
    chk({u_dss_host_model.rxq[0], u_dss_host_model.rxq[1]}, {b1, crc8(b1)});
    rdchk(A_ST, 32'h09, 32'h08);
    $display("done transmit");
    u_dss_host_model.send(8'h00, 1'b0);
    repeat (2 * CPB) @(posedge pclk);
    apb(1'b1, A_ST, 32'h00);
    rdchk(A_ST, 32'h30, 32'h30);
    rdchk(A_CT, 32'h01, 32'h01);
    apb(1'b1, A_ST, 32'h30);
    rdchk(A_ST, 32'h30, 32'h00);
    $display("done break");
    hold_low <= 1'b1;
    apb(1'b1, A_DT, 32'hFF);
    repeat (4 * CPB) @(posedge pclk);
    hold_low <= 1'b0;
    rdchk(A_ST, 32'h04, 32'h04);
    apb(1'b1, A_ST, 32'h04);
    rdchk(A_ST, 32'h04, 32'h00);
    $display("done collision");
    complete_run();
  end
endmodule : debug_serial_status_control_tb
`default_nettype wire
